// ===== verilog/sdc_pkg.sv
/*
  Constants, field layout and types of the SDRAM control register block.
  Assumes a 32-bit classic Wishbone bus and one 20 MHz clock.
*/
package sdc_pkg;
  localparam int          ADDR_W             = 16;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_ADDR_CTRL      = 16'h04F0;
  localparam logic [15:0] IDX_REFRESH_CTRL   = 16'h04F1;
  localparam logic [15:0] IDX_STATUS         = 16'h04F2;
  localparam logic [7:0]  ADDR_CTRL_RESET    = 8'h20;
  localparam logic [7:0]  REFRESH_CTRL_RESET = 8'h00;
  // Address control fields
  localparam int AUTO_INIT_BIT  = 7;
  localparam int WREC_BIT       = 6;
  localparam int DENS_HI_BIT    = 2;
  localparam int DENS_LO_BIT    = 1;
  localparam int MUX_BIT        = 3;
  localparam int ACCESS_BIT     = 0;
  // Refresh control fields
  localparam int SELF_BIT       = 7;
  localparam int INTERVAL_HI    = 6;
  localparam int INTERVAL_LO    = 4;
  localparam int AUTO_SELF_BIT  = 3;
  localparam int AUTO_REF_BIT   = 0;
  // Status fields
  localparam int STAT_INIT_BUSY = 0;
  localparam int STAT_SELF      = 1;
  localparam int STAT_INIT_DONE = 2;
  // Timing
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          SYSCLK_DIV     = 2;
  localparam logic [3:0]  INIT_REF_COUNT = 4'h8;
  localparam logic [1:0]  WREC_SHORT     = 2'h1;
  localparam logic [1:0]  WREC_LONG      = 2'h2;
  localparam logic [8:0]  REF_INTERVAL [8] = '{9'h04E, 9'h061, 9'h07C, 9'h09C,
                                               9'h0C3, 9'h0D2, 9'h0F9, 9'h138};
  // Column widths per density, plain defaults
  localparam int COL_W_16M  = 8;
  localparam int COL_W_64M  = 8;
  localparam int COL_W_128M = 9;

  typedef enum logic [1:0] {
    DENS_16M = 2'h0, DENS_64M = 2'h1, DENS_128M = 2'h2, DENS_RSVD = 2'h3
  } sdc_dens_t;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_PALL = 3'h1, CMD_AREF = 3'h2, CMD_MRS = 3'h3,
    CMD_SREF_IN = 3'h4, CMD_SREF_OUT = 3'h5
  } sdc_cmd_t;

  typedef enum logic [2:0] {
    INIT_IDLE = 3'h0, INIT_PRECH = 3'h1, INIT_REFR = 3'h3, INIT_MODE = 3'h2,
    INIT_DONE = 3'h6
  } sdc_init_t;

  typedef struct packed {
    logic       autoSelfRefresh;
    logic       accessCycle;
    logic [1:0] writeRecovery;
    logic       muxEnable;
    sdc_dens_t  density;
  } sdc_cfg_t;
endpackage

// ===== verilog/sdc_top.sv
/*
  SDRAM control register block: Wishbone slave, init sequencer, refresh timer,
  self refresh control and row/column address multiplexer.
  Assumes synchronous inputs, one clock and a memory sequencer that consumes
  sdramCmd and cfg.
*/
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module sdc_top
  import sdc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [sdc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [23:0]             memAddr,
  input  wire logic                    colPhase,
  output logic      [12:0]             sdramAddr,
  output sdc_pkg::sdc_cmd_t            sdramCmd,
  output sdc_pkg::sdc_cfg_t            cfg
);
  import sdc_pkg::*;

  logic [7:0]  addrCtrl,  next_addrCtrl;
  logic [7:0]  refCtrl,   next_refCtrl;
  logic [31:0] next_wbDat;
  logic        next_wbAck;
  logic [15:0] regIdx;
  logic        wrStrobe;

  assign regIdx   = {2'b00, wb_adr_i[ADDR_W-1:2]};
  assign wrStrobe = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];

  sdc_init_t   initState, next_initState;
  logic [3:0]  initCount, next_initCount;
  logic        initDone,  next_initDone;
  logic        selfActive, next_selfActive;
  logic [8:0]  refCount,  next_refCount;
  logic        stateTick, next_stateTick;
  sdc_cmd_t    next_cmd;
  logic [12:0] next_sdramAddr;
  logic [23:0] rowAddr;
  logic [8:0]  interval;

  // Register bus
  always_comb begin
    next_addrCtrl = addrCtrl;
    next_refCtrl  = refCtrl;
    next_wbAck    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_wbDat    = 32'h0000_0000;
    if (wrStrobe && regIdx == IDX_ADDR_CTRL) begin
      next_addrCtrl = wb_dat_i[7:0];
    end
    if (wrStrobe && regIdx == IDX_REFRESH_CTRL) begin
      next_refCtrl = wb_dat_i[7:0];
    end
    if (next_wbAck && !wb_we_i) begin
      case (regIdx)
        IDX_ADDR_CTRL:    next_wbDat[7:0] = addrCtrl;
        IDX_REFRESH_CTRL: next_wbDat[7:0] = refCtrl;
        IDX_STATUS: begin
          next_wbDat[STAT_INIT_BUSY] = (initState != INIT_IDLE);
          next_wbDat[STAT_SELF]      = selfActive;
          next_wbDat[STAT_INIT_DONE] = initDone;
        end
        default:          next_wbDat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrCtrl <= ADDR_CTRL_RESET;
      refCtrl  <= REFRESH_CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      addrCtrl <= next_addrCtrl;
      refCtrl  <= next_refCtrl;
      wb_ack_o <= next_wbAck;
      wb_dat_o <= next_wbDat;
    end
  end

  // Configuration seen by the memory sequencer
  assign cfg.autoSelfRefresh = refCtrl[AUTO_SELF_BIT];
  assign cfg.accessCycle     = addrCtrl[ACCESS_BIT];
  assign cfg.writeRecovery   = addrCtrl[WREC_BIT] ? WREC_LONG : WREC_SHORT;
  assign cfg.muxEnable       = addrCtrl[MUX_BIT];
  assign cfg.density         = sdc_dens_t'(addrCtrl[DENS_HI_BIT:DENS_LO_BIT]);

  assign interval = REF_INTERVAL[refCtrl[INTERVAL_HI:INTERVAL_LO]];

  // Row part per density; reserved code falls back to the 16 Mbit map
  always_comb begin
    case (cfg.density)
      DENS_64M:  rowAddr = memAddr >> COL_W_64M;
      DENS_128M: rowAddr = memAddr >> COL_W_128M;
      default:   rowAddr = memAddr >> COL_W_16M;
    endcase
  end

  // Sequencer, refresh timer and address mux
  always_comb begin
    next_initState  = initState;
    next_initCount  = initCount;
    next_initDone   = initDone && addrCtrl[AUTO_INIT_BIT];
    next_selfActive = selfActive;
    next_refCount   = refCount;
    next_cmd        = CMD_NOP;
    next_stateTick  = !stateTick;
    if (!refCtrl[AUTO_REF_BIT] || selfActive || initState != INIT_IDLE) begin
      next_refCount = 9'h000;
    end else if (stateTick) begin
      next_refCount = refCount + 9'h001;
    end
    if (stateTick) begin
      case (initState)
        INIT_IDLE: begin
          if (addrCtrl[AUTO_INIT_BIT] && !initDone && !selfActive) begin
            next_initState = INIT_PRECH;
          end else if (refCtrl[SELF_BIT] && !selfActive) begin
            next_cmd        = CMD_SREF_IN;
            next_selfActive = 1'b1;
          end else if (!refCtrl[SELF_BIT] && selfActive) begin
            next_cmd        = CMD_SREF_OUT;
            next_selfActive = 1'b0;
          end else if (refCtrl[AUTO_REF_BIT] && !selfActive
                       && refCount >= interval - 9'h001) begin
            next_cmd      = CMD_AREF;
            next_refCount = 9'h000;
          end
        end
        INIT_PRECH: begin
          next_cmd       = CMD_PALL;
          next_initCount = 4'h0;
          next_initState = INIT_REFR;
        end
        INIT_REFR: begin
          next_cmd       = CMD_AREF;
          next_initCount = initCount + 4'h1;
          if (initCount == INIT_REF_COUNT - 4'h1) begin
            next_initState = INIT_MODE;
          end
        end
        INIT_MODE: begin
          next_cmd       = CMD_MRS;
          next_initState = INIT_DONE;
        end
        INIT_DONE: begin
          next_initDone  = 1'b1;
          next_initState = INIT_IDLE;
        end
        default: next_initState = INIT_IDLE;
      endcase
    end
    if (!cfg.muxEnable) begin
      next_sdramAddr = memAddr[12:0];
    end else if (colPhase) begin
      next_sdramAddr = memAddr[12:0];
    end else begin
      next_sdramAddr = rowAddr[12:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      initState  <= INIT_IDLE;
      initCount  <= 4'h0;
      initDone   <= 1'b0;
      selfActive <= 1'b0;
      refCount   <= 9'h000;
      stateTick  <= 1'b0;
      sdramCmd   <= CMD_NOP;
      sdramAddr  <= 13'h0000;
    end else begin
      initState  <= next_initState;
      initCount  <= next_initCount;
      initDone   <= next_initDone;
      selfActive <= next_selfActive;
      refCount   <= next_refCount;
      stateTick  <= next_stateTick;
      sdramCmd   <= next_cmd;
      sdramAddr  <= next_sdramAddr;
    end
  end

  AST_ACK_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_ACK_NEXT: assert property (@(posedge clk) disable iff (sys_rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
  AST_REG_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    (wrStrobe && regIdx == IDX_ADDR_CTRL) |=> addrCtrl == $past(wb_dat_i[7:0]))
    else $error("address control write lost");
  AST_NO_INIT: assert property (@(posedge clk) disable iff (sys_rst)
    (!addrCtrl[AUTO_INIT_BIT] && initState == INIT_IDLE) |=> initState == INIT_IDLE)
    else $error("init started while disabled");
  AST_INIT_SEQ: assert property (@(posedge clk) disable iff (sys_rst)
    (initState == INIT_PRECH && stateTick) |=> sdramCmd == CMD_PALL ##2 sdramCmd == CMD_AREF)
    else $error("init order wrong");
  AST_WREC: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(addrCtrl[WREC_BIT]) |-> cfg.writeRecovery == 2'h2) else $error("recovery wrong");
  AST_MUX_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    (!cfg.muxEnable && !wrStrobe) |=> sdramAddr == $past(memAddr[12:0]))
    else $error("address muxed while disabled");
  AST_SELF_IN: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(selfActive) |-> sdramCmd == CMD_SREF_IN) else $error("self refresh entry");
  AST_TICK: assert property (@(posedge clk) disable iff (sys_rst)
    stateTick |=> !stateTick ##1 stateTick) else $error("state tick not half rate");
  AST_REF_EN: assert property (@(posedge clk) disable iff (sys_rst)
    (sdramCmd == CMD_AREF && $past(initState) == INIT_IDLE) |-> $past(refCtrl[AUTO_REF_BIT]))
    else $error("refresh while disabled");
  AST_REF_STOP: assert property (@(posedge clk) disable iff (sys_rst)
    (!refCtrl[AUTO_REF_BIT] || selfActive) |=> refCount == 9'h000)
    else $error("interval counter running");
endmodule

// ===== sim/sdc_sdram_model.sv
/*
  SDRAM model at the command pins: follows self refresh, counts refreshes.
  Assumes one-cycle registered command pulses from the controller.
*/
`timescale 1ns/1ps
module sdc_sdram_model
  import sdc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire sdc_pkg::sdc_cmd_t  sdramCmd,
  output int                      arefCount,
  output logic                    inSelf,
  output int                      badCount
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arefCount <= 0;
      inSelf <= 1'b0;
      badCount <= 0;
    end else begin
      if (sdramCmd == CMD_AREF) arefCount <= arefCount + 1;
      if (sdramCmd == CMD_SREF_IN) inSelf <= 1'b1;
      if (sdramCmd == CMD_SREF_OUT) inSelf <= 1'b0;
      // Only no-op and the exit command are legal in self refresh
      if (inSelf && sdramCmd != CMD_NOP && sdramCmd != CMD_SREF_OUT)
        badCount <= badCount + 1;
    end
  end
endmodule

// ===== sim/test_sdc_top.sv
/*
  Self-checking bench of the SDRAM control registers.
  Assumes sdc_pkg and the SDRAM model are compiled first.
*/
`timescale 1ns/1ps
module test_sdc_top;
  import sdc_pkg::*;
  logic        clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, colPhase = 0, ack, inSelf;
  logic [15:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] wdat = '0, rd, dato;
  logic [23:0] memAddr = 24'hAB_CDEF, e;
  logic [12:0] sdramAddr;
  sdc_cmd_t    cmd;
  sdc_cfg_t    cfg;
  int          failures = 0, compares = 0, cycles = 0, n, k, arefCount, badCount;
  logic [15:0] rows [3] = '{16'h2008, 16'h6A15, 16'h252A};
  int          colW [4] = '{8, 8, 9, 0};
  int          ivl [8] = '{78, 97, 124, 156, 195, 210, 249, 312};
  always #25 clk = ~clk;
  sdc_top dut(.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .memAddr(memAddr), .colPhase(colPhase), .sdramAddr(sdramAddr), .sdramCmd(cmd), .cfg(cfg));
  sdc_sdram_model mem(.clk(clk), .sys_rst(sys_rst), .sdramCmd(cmd), .arefCount(arefCount),
    .inSelf(inSelf), .badCount(badCount));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, entered and left just after a rising edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t >= 20) failures++;
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Cycles until the next command other than no-op; now also takes one already standing
  task automatic nxt(input bit now);
    n = 0;
    if (!now || cmd === CMD_NOP) begin
      do begin
        @(posedge clk);
        n++;
      end while (cmd === CMD_NOP && n < 2000);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wb(0, 16'h13C0, 4'h1, 0);
    chk(rd, 32'h20);
    chk(cfg.writeRecovery, 2'h1);
    wb(0, 16'h13C4, 4'h1, 0);
    chk(rd, 32'h00);
    wb(0, 16'h13C8, 4'h1, 0);
    chk(rd, 32'h0);
    for (k = 0; k < 3; k++) begin
      wb(1, 16'h13C0, 4'h1, rows[k][15:8]);
      chk(cfg, rows[k][6:0]);
      wb(0, 16'h13C0, 4'h1, 0);
      chk(rd, rows[k][15:8]);
    end
    for (k = 0; k < 4; k++) begin
      wb(1, 16'h13C0, 4'h1, (k < 3) ? 8'h28 | (k << 1) : 8'h20);
      for (int p = 0; p < 2; p++) begin
        colPhase <= p[0];
        repeat (2) @(posedge clk);
        e = (p == 1 || k == 3) ? memAddr : memAddr >> colW[k];
        chk(sdramAddr, e[12:0]);
      end
    end
    for (k = 0; k < 8; k++) begin
      wb(1, 16'h13C4, 4'h1, {k[2:0], 4'h1});
      nxt(1'b0);
      nxt(1'b0);
      chk(n, 2 * ivl[k]);
    end
    wb(1, 16'h13C4, 4'h1, 8'h80);
    nxt(1'b1);
    chk(cmd, CMD_SREF_IN);
    wb(0, 16'h13C8, 4'h1, 0);
    chk(rd, 32'h2);
    wb(1, 16'h13C4, 4'h1, 8'h81);
    k = arefCount;
    repeat (800) @(posedge clk);
    chk(arefCount, k);
    wb(1, 16'h13C4, 4'h1, 8'h01);
    nxt(1'b1);
    chk(cmd, CMD_SREF_OUT);
    wb(1, 16'h13C4, 4'h1, 8'h00);
    wb(1, 16'h13C0, 4'h1, 8'hA0);
    nxt(1'b0);
    chk(cmd, CMD_PALL);
    repeat (8) begin
      nxt(1'b0);
      chk(cmd, CMD_AREF);
      chk(n, 2);
    end
    nxt(1'b0);
    chk(cmd, CMD_MRS);
    // Done flag settles one state after the mode command
    repeat (2) @(posedge clk);
    wb(0, 16'h13C8, 4'h1, 0);
    chk(rd, 32'h4);
    wb(0, 16'h13CC, 4'h1, 0);
    chk(rd, 32'h0);
    wb(1, 16'h13C4, 4'h0, 8'h80);
    wb(0, 16'h13C4, 4'h1, 0);
    chk(rd, 32'h0);
    chk(badCount, 0);
    // Reset in mid-run brings both registers back
    wb(1, 16'h13C0, 4'h1, 8'h6A);
    wb(1, 16'h13C4, 4'h1, 8'h70);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(cfg.writeRecovery, 2'h1);
    wb(0, 16'h13C0, 4'h1, 0);
    chk(rd, 32'h20);
    wb(0, 16'h13C4, 4'h1, 0);
    chk(rd, 32'h00);
    complete_run();
  end
endmodule
